// file: rtl/suspend_resume_power_sequencer.sv
// ----------------------------------------------------------------------------
// Purpose: Power-state sequencer for planes, clock stops, sleep and resets
// Assumes: Pin inputs are asynchronous; one 100 MHz clock
// Notes:   Every timed step is aligned to the real-time tick
// ----------------------------------------------------------------------------
// Overview of operation
// - Steps are timed in 32 us ticks
// - Reset asserts status, planes off, clock low
// - Planes released one to two ticks later
// - Power good low: float stops, assert resets
// - Core first: sleep and stop inactive
// - Reset released first: sleep and stop active
// - Power good drives clock stops active
// - Early release keeps sleep and stop inactive
// - Late release pulses sleep, ends 1-2 ticks
// - Wait 16 ms and good before stop release
// - Late good: release one to two ticks after good
// - Status released 1 ms after stop release
// - Refresh clock starts with status release
// - PCI reset released one tick after status
// - Processor reset released one tick later
// ----------------------------------------------------------------------------
`timescale 1ns/1ps

module suspend_resume_power_sequencer #(
   parameter int unsigned TICK_CYCLES = power_seq_pkg::TICK_CYCLES
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic suspend_well_reset_n,
   input wire logic core_power_good,
   input wire logic core_power_present,
   output power_seq_pkg::power_pins_t pins
);

   // ------------------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------------------
   if (TICK_CYCLES < 2)
   begin : g_bad_tick
      $error("Tick must span at least two cycles");
   end

   // ------------------------------------------------------------------------
   // Timebase and synchronised inputs
   // ------------------------------------------------------------------------
   logic tick; // One-cycle pulse per tick
   logic phase; // Half-duty level per tick
   logic [power_seq_pkg::SYNC_WIDTH-1:0] pin_raw; // Raw pin levels
   logic [power_seq_pkg::SYNC_WIDTH-1:0] pin_lvl; // Synchronised levels
   logic sus_rst; // Suspend-well reset held
   logic pg; // Core power good
   logic core_on; // Core power present

   // Timebase for every step
   rt_tick_gen #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .tick(tick),
      .phase(phase)
   );

   assign pin_raw[power_seq_pkg::IDX_SUS_RST_N] = suspend_well_reset_n;
   assign pin_raw[power_seq_pkg::IDX_PWR_GOOD] = core_power_good;
   assign pin_raw[power_seq_pkg::IDX_CORE_ON] = core_power_present;

   // Synchronise all pins before use
   pin_sync #(
      .WIDTH(power_seq_pkg::SYNC_WIDTH),
      .RESET_VALUE(power_seq_pkg::SYNC_RESET_VALUE)
   ) u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .pin_in(pin_raw),
      .level_out(pin_lvl)
   );

   assign sus_rst = !pin_lvl[power_seq_pkg::IDX_SUS_RST_N];
   assign pg = pin_lvl[power_seq_pkg::IDX_PWR_GOOD];
   assign core_on = pin_lvl[power_seq_pkg::IDX_CORE_ON];

   // ------------------------------------------------------------------------
   // Main sequence state
   // ------------------------------------------------------------------------
   power_seq_pkg::seq_state_t state_q; // Current step
   power_seq_pkg::seq_state_t state_d;
   logic [power_seq_pkg::SEQ_CNT_W-1:0] cnt_q; // Ticks spent in this step
   logic [power_seq_pkg::SEQ_CNT_W-1:0] cnt_d;
   logic [1:0] pg_ticks_q; // Ticks since power good, saturating
   logic [1:0] pg_ticks_d;

   // Next step of the sequence
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q;
      pg_ticks_d = pg_ticks_q;
      // Ticks since power good rose, cleared while it is low
      if (!pg)
      begin
         pg_ticks_d = 2'h0;
      end
      else if (tick && pg_ticks_q != power_seq_pkg::SAT2_MAX)
      begin
         pg_ticks_d = pg_ticks_q + 2'h1;
      end
      if (sus_rst)
      begin
         // Suspend reset wins at once over every other step
         state_d = power_seq_pkg::ST_MECH_OFF;
         cnt_d = power_seq_pkg::SEQ_CNT_ZERO;
      end
      else
      begin
         case (state_q)
            power_seq_pkg::ST_MECH_OFF:
            begin
               // Release seen, start counting ticks
               state_d = power_seq_pkg::ST_PLANE_WAIT;
               cnt_d = power_seq_pkg::SEQ_CNT_ZERO;
            end
            power_seq_pkg::ST_PLANE_WAIT:
            begin
               // Planes come on at the second tick edge
               if (tick)
               begin
                  if (cnt_q == power_seq_pkg::PLANE_RELEASE_CNT)
                  begin
                     state_d = power_seq_pkg::ST_PLL_WAIT;
                     cnt_d = power_seq_pkg::SEQ_CNT_ZERO;
                  end
                  else
                  begin
                     cnt_d = cnt_q + 10'h001;
                  end
               end
            end
            power_seq_pkg::ST_PLL_WAIT:
            begin
               // Whole ticks of lock time, then power good
               if (tick)
               begin
                  // Lock count rounded up to whole ticks
                  if (cnt_q != power_seq_pkg::PLL_LOCK_CNT)
                  begin
                     cnt_d = cnt_q + 10'h001;
                  end
                  // Second tick edge after good, so a full tick
                  else if (pg && pg_ticks_q != 2'h0)
                  begin
                     state_d = power_seq_pkg::ST_STAT_WAIT;
                     cnt_d = power_seq_pkg::SEQ_CNT_ZERO;
                  end
               end
            end
            power_seq_pkg::ST_STAT_WAIT:
            begin
               // Hold status for the rounded-up wait
               if (tick)
               begin
                  if (cnt_q == power_seq_pkg::STATUS_HOLD_CNT)
                  begin
                     state_d = power_seq_pkg::ST_PCI_RST;
                  end
                  else
                  begin
                     cnt_d = cnt_q + 10'h001;
                  end
               end
            end
            power_seq_pkg::ST_PCI_RST:
            begin
               // PCI reset ends at the next tick
               if (tick)
               begin
                  state_d = power_seq_pkg::ST_CPU_RST;
               end
            end
            power_seq_pkg::ST_CPU_RST:
            begin
               // Processor reset ends at the next tick
               if (tick)
               begin
                  state_d = power_seq_pkg::ST_ON;
               end
            end
            power_seq_pkg::ST_ON:
            begin
               // Stay on while power is good
               state_d = power_seq_pkg::ST_ON;
            end
            default:
            begin
               state_d = power_seq_pkg::ST_MECH_OFF;
               cnt_d = power_seq_pkg::SEQ_CNT_ZERO;
            end
         endcase
         // Loss of power good returns to the lock wait, lock time kept
         if (!pg && state_q != power_seq_pkg::ST_MECH_OFF &&
             state_q != power_seq_pkg::ST_PLANE_WAIT &&
             state_q != power_seq_pkg::ST_PLL_WAIT)
         begin
            state_d = power_seq_pkg::ST_PLL_WAIT;
            cnt_d = power_seq_pkg::PLL_LOCK_CNT;
         end
      end
   end

   // Register the sequence state
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q <= power_seq_pkg::ST_MECH_OFF;
         cnt_q <= power_seq_pkg::SEQ_CNT_ZERO;
         pg_ticks_q <= 2'h0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         pg_ticks_q <= pg_ticks_d;
      end
   end

   // ------------------------------------------------------------------------
   // Processor sleep and clock-stop handling at power-up
   // ------------------------------------------------------------------------
   logic core_first_q; // Core power was on before reset release
   logic core_first_d;
   logic [1:0] rel_ticks_q; // Ticks since reset release, saturating
   logic [1:0] rel_ticks_d;
   logic sleep_q; // Sleep and clock stop requested
   logic sleep_d;
   logic pg_prev_q; // Power good one cycle ago
   logic pg_prev_d;

   // Decide whether sleep and stop are active
   always_comb
   begin
      core_first_d = core_first_q;
      rel_ticks_d = rel_ticks_q;
      sleep_d = sleep_q;
      pg_prev_d = pg;
      if (sus_rst)
      begin
         // Remember which power came first, sleep off
         core_first_d = core_on;
         rel_ticks_d = 2'h0;
         sleep_d = 1'b0;
      end
      else
      begin
         if (tick && rel_ticks_q != power_seq_pkg::SAT2_MAX)
         begin
            rel_ticks_d = rel_ticks_q + 2'h1;
         end
         if (!pg)
         begin
            // Core first keeps them off, release first asserts them
            sleep_d = !core_first_q;
         end
         else if (!pg_prev_q)
         begin
            // Early release keeps them off, late release pulses them
            sleep_d = sleep_q || (rel_ticks_q < power_seq_pkg::SLEEP_KEEP_OFF_CNT);
         end
         else if (tick && pg_ticks_q == power_seq_pkg::SLEEP_RELEASE_CNT)
         begin
            // End the pulse at the second tick after good
            sleep_d = 1'b0;
         end
      end
   end

   // Register the sleep state
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         core_first_q <= 1'b0;
         rel_ticks_q <= 2'h0;
         sleep_q <= 1'b0;
         pg_prev_q <= 1'b0;
      end
      else
      begin
         core_first_q <= core_first_d;
         rel_ticks_q <= rel_ticks_d;
         sleep_q <= sleep_d;
         pg_prev_q <= pg_prev_d;
      end
   end

   // ------------------------------------------------------------------------
   // Output pins
   // ------------------------------------------------------------------------
   power_seq_pkg::power_pins_t pins_q; // Registered pin values
   power_seq_pkg::power_pins_t pins_d;
   logic stops_off; // Stop requests released
   logic status_off; // Suspend status released
   logic planes_on; // Planes powered

   // Derive the pins from the sequence state, power good and the sleep state
   always_comb
   begin
      planes_on = (state_q != power_seq_pkg::ST_MECH_OFF) &&
                  (state_q != power_seq_pkg::ST_PLANE_WAIT);
      stops_off = planes_on && (state_q != power_seq_pkg::ST_PLL_WAIT);
      status_off = stops_off && (state_q != power_seq_pkg::ST_STAT_WAIT);
      pins_d = pins_q;
      // Status and planes low while held
      pins_d.suspend_status_n = status_off ? 2'h3 : 2'h0;
      pins_d.plane_off_n = planes_on ? 3'h7 : 3'h0;
      // Refresh clock low until status release, then runs
      pins_d.suspend_refresh_clock = status_off && phase;
      // Float without good, else driven low until released
      pins_d.cpu_clock_stop_req_oe = pg;
      pins_d.pci_clock_stop_req_oe = pg;
      pins_d.cpu_clock_stop_req_n = stops_off;
      pins_d.pci_clock_stop_req_n = stops_off;
      // Resets held without good or before their step
      pins_d.pci_bus_reset_n = pg && (state_q == power_seq_pkg::ST_CPU_RST ||
                                      state_q == power_seq_pkg::ST_ON);
      pins_d.processor_reset = !(pg && state_q == power_seq_pkg::ST_ON);
      pins_d.processor_sleep_n = !sleep_q;
      pins_d.processor_clock_stop_n = !sleep_q;
   end

   // Register the pins
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pins_q <= power_seq_pkg::PINS_RESET;
      end
      else
      begin
         pins_q <= pins_d;
      end
   end

   assign pins = pins_q;

endmodule : suspend_resume_power_sequencer

// file: rtl/power_seq_pkg.sv
// ----------------------------------------------------------------------------
// Purpose: Shared constants and types for the suspend/resume power sequencer
// Assumes: A single 100 MHz system clock drives every flip-flop
// Notes:   Times are kept in their own units and converted to cycles or ticks
// ----------------------------------------------------------------------------
package power_seq_pkg;

   // -------------------------------------------------------------------------
   // Clock and timebase
   // -------------------------------------------------------------------------
   localparam int unsigned CLK_FREQ_HZ = 100_000_000; // System clock rate
   localparam int unsigned TICK_TIME_US = 32; // One real-time tick
   // Cycles in one tick, 3200 at 100 MHz
   localparam int unsigned TICK_CYCLES = (TICK_TIME_US * (CLK_FREQ_HZ / 1_000_000));
   localparam int unsigned TICK_CNT_W = 12; // Width of the tick divider

   // -------------------------------------------------------------------------
   // Sequencing waits, in their own units and in ticks (rounded up)
   // -------------------------------------------------------------------------
   localparam int unsigned PLL_LOCK_TIME_MS = 16; // Synthesizer lock wait
   localparam int unsigned STATUS_HOLD_TIME_MS = 1; // Stop release to status release
   localparam int unsigned TICK_TIME_NS = TICK_TIME_US * 1000; // Tick in ns
   localparam int unsigned PLL_LOCK_TICKS =
      (PLL_LOCK_TIME_MS * 1_000_000 + TICK_TIME_NS - 1) / TICK_TIME_NS;
   localparam int unsigned STATUS_HOLD_TICKS =
      (STATUS_HOLD_TIME_MS * 1_000_000 + TICK_TIME_NS - 1) / TICK_TIME_NS;
   localparam int unsigned SEQ_CNT_W = 10; // Width of the sequence counter
   localparam logic [SEQ_CNT_W-1:0] PLL_LOCK_CNT = SEQ_CNT_W'(PLL_LOCK_TICKS);
   localparam logic [SEQ_CNT_W-1:0] STATUS_HOLD_CNT = SEQ_CNT_W'(STATUS_HOLD_TICKS);
   localparam logic [SEQ_CNT_W-1:0] PLANE_RELEASE_CNT = 10'h001; // Release on 2nd tick
   localparam logic [1:0] SLEEP_RELEASE_CNT = 2'h1; // Sleep ends on 2nd tick after good
   localparam logic [1:0] SLEEP_KEEP_OFF_CNT = 2'h2; // Early release keeps sleep off
   localparam logic [1:0] SAT2_MAX = 2'h3; // Saturation of the 2-bit tick counters
   localparam logic [SEQ_CNT_W-1:0] SEQ_CNT_ZERO = 10'h000; // Counter restart value

   // -------------------------------------------------------------------------
   // Input synchroniser
   // -------------------------------------------------------------------------
   localparam int unsigned SYNC_WIDTH = 3; // Number of pins synchronised
   localparam int unsigned IDX_SUS_RST_N = 0; // Suspend-well reset, active low
   localparam int unsigned IDX_PWR_GOOD = 1; // Core power good
   localparam int unsigned IDX_CORE_ON = 2; // Core power present
   localparam logic [SYNC_WIDTH-1:0] SYNC_RESET_VALUE = 3'h0; // All absent at reset

   // -------------------------------------------------------------------------
   // Sequencer states
   // -------------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_MECH_OFF,   // Suspend-well reset held
      ST_PLANE_WAIT, // Reset released, planes still off
      ST_PLL_WAIT,   // Planes on, waiting for lock time and power good
      ST_STAT_WAIT,  // Stop requests released, holding suspend status
      ST_PCI_RST,    // Status released, PCI reset still held
      ST_CPU_RST,    // PCI reset released, processor reset held
      ST_ON          // Fully on
   } seq_state_t;

   // -------------------------------------------------------------------------
   // Output pin bundle
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] suspend_status_n;       // Suspend status, active low
      logic [2:0] plane_off_n;            // Plane-off controls, active low
      logic suspend_refresh_clock;        // Suspend refresh clock
      logic cpu_clock_stop_req_n;         // CPU clock stop, active low
      logic cpu_clock_stop_req_oe;        // High while driven
      logic pci_clock_stop_req_n;         // PCI clock stop, active low
      logic pci_clock_stop_req_oe;        // High while driven
      logic pci_bus_reset_n;              // PCI bus reset, active low
      logic processor_reset;              // Processor reset, active high
      logic processor_sleep_n;            // Processor sleep, active low
      logic processor_clock_stop_n;       // Processor clock stop, active low
   } power_pins_t;

   localparam power_pins_t PINS_RESET = 14'h0007; // Mech-off values at reset

endpackage : power_seq_pkg

// file: rtl/pin_sync.sv
// ----------------------------------------------------------------------------
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous levels
// Notes:   The filtered level changes only when stages two and three agree
// ----------------------------------------------------------------------------
`timescale 1ns/1ps

module pin_sync #(
   parameter int unsigned WIDTH = power_seq_pkg::SYNC_WIDTH,
   parameter logic [WIDTH-1:0] RESET_VALUE = power_seq_pkg::SYNC_RESET_VALUE
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out
);

   // ----------------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------------
   if (WIDTH < 1)
   begin : g_bad_width
      $error("pin_sync needs at least one bit");
   end

   // ----------------------------------------------------------------------
   // Per-bit stages
   // ----------------------------------------------------------------------
   genvar gi;
   for (gi = 0; gi < WIDTH; gi++)
   begin : g_bit
      logic meta_q; // First stage, read only by the second
      logic mid_q; // Second stage
      logic last_q; // Third stage
      logic filt_q; // Agreed level
      logic filt_d; // Next agreed level

      // Accept a new level once stages two and three agree
      always_comb
      begin
         filt_d = (mid_q == last_q) ? last_q : filt_q;
      end

      // Register the chain
      always_ff @(posedge clk_sys or negedge reset_n)
      begin
         if (!reset_n)
         begin
            meta_q <= RESET_VALUE[gi];
            mid_q <= RESET_VALUE[gi];
            last_q <= RESET_VALUE[gi];
            filt_q <= RESET_VALUE[gi];
         end
         else
         begin
            meta_q <= pin_in[gi];
            mid_q <= meta_q;
            last_q <= mid_q;
            filt_q <= filt_d;
         end
      end

      assign level_out[gi] = filt_q;
   end

endmodule : pin_sync

// file: rtl/rt_tick_gen.sv
// ----------------------------------------------------------------------------
// Purpose: Real-time timebase, one tick pulse and a half-duty phase per tick
// Assumes: TICK_CYCLES system clocks make one tick
// Notes:   The phase output feeds the suspend refresh clock
// ----------------------------------------------------------------------------
`timescale 1ns/1ps

module rt_tick_gen #(
   parameter int unsigned TICK_CYCLES = power_seq_pkg::TICK_CYCLES
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   output logic tick,
   output logic phase
);

   localparam int unsigned CW = power_seq_pkg::TICK_CNT_W; // Counter width
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1); // Final count
   localparam logic [CW-1:0] HALF = CW'(TICK_CYCLES / 2); // Phase rises here

   // ----------------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------------
   if (TICK_CYCLES < 2 || TICK_CYCLES > (1 << CW))
   begin : g_bad_tick
      $error("rt_tick_gen cannot serve this tick length");
   end

   logic [CW-1:0] cnt_q; // Cycle counter
   logic [CW-1:0] cnt_d;
   logic tick_q; // Registered tick pulse
   logic tick_d;
   logic phase_q; // Registered phase level
   logic phase_d;

   // Count cycles and derive tick and phase
   always_comb
   begin
      cnt_d = (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
      tick_d = (cnt_q == LAST);
      phase_d = (cnt_d >= HALF);
   end

   // Register counter and outputs
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt_q <= '0;
         tick_q <= 1'b0;
         phase_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
         phase_q <= phase_d;
      end
   end

   assign tick = tick_q;
   assign phase = phase_q;

endmodule : rt_tick_gen

// file: tb/seq_checker_asserts.sv
// Purpose: Pin timing checks for the power sequencer
// Assumes: TICK_CYCLES as in the design
// Notes:   Bounds allow for synchroniser delay
`timescale 1ns/1ps
module seq_checker #(parameter int TICK_CYCLES = 8) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic suspend_well_reset_n,
   input wire logic core_power_good,
   input wire logic core_power_present,
   input wire power_seq_pkg::power_pins_t pins
);
   localparam int T1 = TICK_CYCLES + 6; // One tick and slack
   localparam int T2 = 2 * TICK_CYCLES + 6; // Two ticks and slack
   int up_q, stop_q, good_q; // Cycles since planes on, stops off, good
   // Elapsed-time counters
   always_ff @(posedge clk_sys)
   begin
      up_q <= (pins.plane_off_n == 3'h7) ? up_q + 1 : 0;
      stop_q <= pins.cpu_clock_stop_req_n ? stop_q + 1 : 0;
      good_q <= core_power_good ? good_q + 1 : 0;
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   a_mech_off: assert property ($fell(suspend_well_reset_n) |-> ##[1:T1]
      (pins.suspend_status_n == 2'h0 && pins.plane_off_n == 3'h0 &&
      !pins.suspend_refresh_clock)) else $error("mech off");
   a_plane_on: assert property ($rose(suspend_well_reset_n) |-> ##[1:T2]
      pins.plane_off_n == 3'h7) else $error("planes");
   a_float_bad: assert property ($fell(core_power_good) |-> ##[1:T1]
      (!pins.cpu_clock_stop_req_oe && !pins.pci_clock_stop_req_oe &&
      !pins.pci_bus_reset_n && pins.processor_reset)) else $error("float");
   a_sleep_start: assert property ($rose(suspend_well_reset_n) |->
      ##T1 (core_power_good || {pins.processor_sleep_n, pins.processor_clock_stop_n} ==
      {2{$past(core_power_present, T1)}})) else $error("sleep");
   a_sleep_end: assert property ($rose(core_power_good) |-> ##T2
      (pins.processor_sleep_n && pins.processor_clock_stop_n)) else $error("sleep end");
   a_stops_good: assert property ($rose(core_power_good) |-> ##[1:T1]
      (pins.cpu_clock_stop_req_oe && pins.pci_clock_stop_req_oe &&
      !pins.cpu_clock_stop_req_n && !pins.pci_clock_stop_req_n)) else $error("stops");
   a_lock_wait: assert property ($rose(pins.cpu_clock_stop_req_n)
      && pins.cpu_clock_stop_req_oe |-> up_q >= 500 * TICK_CYCLES - 1 &&
      good_q >= TICK_CYCLES) else $error("lock");
   a_status_hold: assert property ($rose(pins.suspend_status_n[0])
      |-> stop_q >= 32 * TICK_CYCLES - 1) else $error("status");
   a_refresh_run: assert property ($rose(pins.suspend_status_n[0])
      |-> ##[1:T1] pins.suspend_refresh_clock) else $error("refresh");
   a_reset_order: assert property ($rose(pins.suspend_status_n[0])
      |-> ##[1:T1] pins.pci_bus_reset_n ##[1:T1] !pins.processor_reset) else $error("resets");
endmodule : seq_checker
bind suspend_resume_power_sequencer seq_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (.*);

// file: tb/power_supervisor.sv
// Purpose: Supervisor model for the power status pins
// Assumes: Pins change on falling edges
// Notes:   HOLD cycles stand for the 1 ms holds
`timescale 1ns/1ps
module power_supervisor #(parameter int HOLD = 40) (
   input wire logic clk_sys,
   input wire power_seq_pkg::power_pins_t pins,
   output logic suspend_well_reset_n = 1'b0,
   output logic core_power_present = 1'b0,
   output logic core_power_good = 1'b0,
   output logic clocks_running
);
   logic [1:0] run_q = 2'h0; // Synthesizer start-up delay line
   // Clocks run two cycles after both stop requests release
   // Plain restart: no distributed DMA or serial interrupts here
   always @(posedge clk_sys)
      run_q <= {run_q[0], pins.cpu_clock_stop_req_n & pins.pci_clock_stop_req_n};
   assign clocks_running = run_q[1];
   // Set reset, core power and good, then wait n cycles
   task automatic put(input logic [2:0] v, input int n);
      {suspend_well_reset_n, core_power_present, core_power_good} = v;
      repeat (n) @(negedge clk_sys);
   endtask : put
   // Core power before or after reset release, good later
   task automatic power_up(input logic cf, input int gap);
      put({1'b0, cf, 1'b0}, HOLD);
      put({1'b1, cf, 1'b0}, gap);
      if (!cf)
         put(3'h6, HOLD);
      put(3'h7, 0);
   endtask : power_up
endmodule : power_supervisor

// file: tb/suspend_resume_power_sequencer_test.sv
// Purpose: Self-checking bench for the power sequencer
// Assumes: Tick shortened to T cycles
// Notes:   Supervisor model drives the status pins
`timescale 1ns/1ps
module suspend_resume_power_sequencer_test;
   localparam int T = 8; // Shortened tick
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   wire logic suspend_well_reset_n, core_power_good, core_power_present, clocks_running;
   power_seq_pkg::power_pins_t pins;
   int num_errors = 0, total_checks = 0, cyc = 0, gap;
   logic cf, saw = 1'b0; // Core first, sleep pulse seen
   always #5 clk_sys = ~clk_sys;
   suspend_resume_power_sequencer #(.TICK_CYCLES(T)) dut (.*);
   power_supervisor sup (.*);
   // Cycle count, sleep pulse watch, hang limit
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      saw <= saw | (core_power_good & !pins.processor_sleep_n);
      if (cyc == 50000)
      begin
         num_errors++;
         conclude();
      end
   end
   task automatic check(input string what, input logic [15:0] got, exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // A sleep pulse is due unless core came first and release led good by two ticks
   function automatic logic pulse_expected(input logic core_first, input int gap_cyc);
      return !core_first || gap_cyc < 2 * T;
   endfunction : pulse_expected
   // Wait for processor reset release, then check on-state pins
   task automatic wait_on();
      for (int n = 0; n < 6000 && pins.processor_reset !== 1'b0; n++)
         @(negedge clk_sys);
      check("on", {pins.suspend_status_n, pins.plane_off_n, clocks_running,
         pins.pci_bus_reset_n, pins.processor_reset}, 8'hFE);
   endtask : wait_on
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude
   initial
   begin
      gap = $urandom(32'hC94D5DB3);
      repeat (8) @(negedge clk_sys);
      reset_n = 1'b1;
      check("reset", {pins.plane_off_n, pins.processor_reset}, 4'h1);
      for (int i = 0; i < 4; i++)
      begin
         cf = (i == 0) ? 1'b0 : ((i < 3) ? 1'b1 : 1'($urandom % 2));
         gap = (i == 2) ? 4 * T : ((i < 2) ? 2 : 1 + $urandom % T);
         saw = 1'b0;
         sup.power_up(cf, gap);
         wait_on();
         check("pulse", saw, pulse_expected(cf, gap));
         sup.put(3'h6, 2 * T);
         check("float", {pins.cpu_clock_stop_req_oe, pins.processor_reset}, 2'h1);
         sup.put(3'h7, 0);
         wait_on();
         sup.put(3'h0, 40);
         check("off", {pins.suspend_status_n, pins.plane_off_n}, 5'h00);
      end
      conclude();
   end
endmodule : suspend_resume_power_sequencer_test
